// ===== rtl/pll_cfg_pkg.sv
package pll_cfg_pkg;

    // ==========================================================
    // register indexes; byte address is four times the index
    localparam logic [4:0] IDX_LOOP_CTRL = 5'h10;
    localparam logic [4:0] IDX_REF_LOW = 5'h11;
    localparam logic [4:0] IDX_REF_HIGH = 5'h12;
    localparam logic [4:0] IDX_SWALLOW = 5'h13;
    localparam logic [4:0] IDX_MAIN_LOW = 5'h14;
    localparam logic [4:0] IDX_MAIN_HIGH = 5'h15;
    localparam logic [4:0] IDX_PIN_CTRL = 5'h16;
    localparam logic [4:0] IDX_STATUS = 5'h17;

    // ==========================================================
    // reset values
    localparam logic [7:0] RST_LOOP_CTRL = 8'h7D;
    localparam logic [7:0] RST_REF_LOW = 8'h01;
    localparam logic [5:0] RST_REF_HIGH = 6'h00;
    localparam logic [5:0] RST_SWALLOW = 6'h00;
    localparam logic [7:0] RST_MAIN_LOW = 8'h03;
    localparam logic [4:0] RST_MAIN_HIGH = 5'h00;
    localparam logic [7:0] RST_PIN_CTRL = 8'h00;

    // ==========================================================
    // field widths and positions
    localparam int REF_W = 14;
    localparam int SWALLOW_W = 6;
    localparam int MAIN_W = 13;
    localparam int REF_HIGH_W = 6;
    localparam int MAIN_HIGH_W = 5;
    localparam int POL_BIT = 7;
    localparam int CUR_LSB = 4;
    localparam int CUR_W = 3;
    localparam int MODE_LSB = 2;
    localparam int PD_LSB = 0;
    localparam int MID_BIT = 7;
    localparam int RST_REF_BIT = 6;
    localparam int RST_FB_BIT = 5;
    localparam int RST_ALL_BIT = 4;
    localparam int BYPASS_BIT = 3;

    // ==========================================================
    // field encodings
    typedef enum logic [1:0] {
        PUMP_HIZ = 2'h0,
        PUMP_FORCE_UP = 2'h1,
        PUMP_FORCE_DOWN = 2'h2,
        PUMP_NORMAL = 2'h3
    } pump_force_mode_t;

    typedef enum logic [1:0] {
        LOOP_RUN = 2'h0,
        LOOP_PD_ASYNC = 2'h1,
        LOOP_UNUSED = 2'h2,
        LOOP_PD_SYNC = 2'h3
    } loop_power_t;

endpackage

// ===== rtl/loop_counter.sv
`timescale 1ns/1ns
module loop_counter #(
    parameter int W = 14
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // control
    input wire logic hold,
    input wire logic [W-1:0] divide,
    // result
    output logic tick
);

    // ==========================================================
    // down counter, period is divide (0 behaves as 1)
    logic [W-1:0] count;
    wire at_end = (count == '0);
    wire [W-1:0] reload = (divide == '0) ? '0 : divide - W'(1);

    always_ff @(posedge clk_sys) begin
        if (!resetn || hold) begin
            count <= '0;
            tick <= 1'b0;
        end else begin
            count <= at_end ? reload : count - W'(1);
            tick <= at_end;
        end
    end

endmodule

// ===== rtl/pump_drive.sv
`timescale 1ns/1ns
module pump_drive (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // settings
    input wire pll_cfg_pkg::pump_force_mode_t mode,
    input wire logic loop_on,
    input wire logic set_mid,
    input wire logic pfd_up,
    input wire logic pfd_down,
    // pump controls
    output logic pump_up,
    output logic pump_down,
    output logic pump_hiz,
    output logic pump_mid
);

    logic next_up;
    logic next_down;

    // ==========================================================
    // mode decode; mid-supply overrides everything
    always_comb begin
        next_up = 1'b0;
        next_down = 1'b0;
        unique case (mode)
            pll_cfg_pkg::PUMP_HIZ: begin
            end
            pll_cfg_pkg::PUMP_FORCE_UP: begin
                next_up = 1'b1;
            end
            pll_cfg_pkg::PUMP_FORCE_DOWN: begin
                next_down = 1'b1;
            end
            pll_cfg_pkg::PUMP_NORMAL: begin
                next_up = pfd_up;
                next_down = pfd_down;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pump_up <= 1'b0;
            pump_down <= 1'b0;
            pump_hiz <= 1'b1;
            pump_mid <= 1'b0;
        end else begin
            pump_up <= loop_on && !set_mid && next_up;
            pump_down <= loop_on && !set_mid && next_down;
            pump_hiz <= !loop_on || set_mid || !(next_up || next_down);
            pump_mid <= set_mid;
        end
    end

endmodule

// ===== rtl/pll_divider_config_regs.sv
// What this block does
// - loop power-down field runs the loop only at 00; other codes power it down.
// - pump mode 01 forces continuous source current on the charge pump.
// - pump mode 10 forces continuous sink current on the charge pump.
// - reference divider bits 7..0 live at index 0x011, reset 0x01.
// - reference divider bits 13..8 live at 0x012 bits 5..0, reset zero.
// - six-bit swallow count lives at 0x013 bits 5..0, reset zero.
// - feedback main count bits 7..0 live at 0x014, reset 0x03.
// - feedback main count bits 12..8 live at 0x015 bits 4..0, reset zero.
`timescale 1ns/1ns
module pll_divider_config_regs (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    // phase detector requests
    input wire logic pfd_up,
    input wire logic pfd_down,
    // charge pump
    output logic pump_up,
    output logic pump_down,
    output logic pump_hiz,
    output logic pump_mid,
    output logic [2:0] pump_current,
    output logic pfd_negative,
    // loop counters
    output logic ref_tick,
    output logic fb_tick,
    output logic [5:0] swallow_out
);

    // ==========================================================
    // registers
    logic [7:0] loop_ctrl;
    logic [7:0] ref_low;
    logic [5:0] ref_high;
    logic [5:0] swallow;
    logic [7:0] main_low;
    logic [4:0] main_high;
    logic [7:0] pin_ctrl;
    logic pfd_up_s1;
    logic pfd_up_s2;
    logic pfd_down_s1;
    logic pfd_down_s2;

    // ==========================================================
    // bus decode; the write lands on the edge the master sees ack
    wire [4:0] index = wb_adr_i[6:2];
    wire in_range = (wb_adr_i[7] == 1'b0) && (wb_adr_i[1:0] == 2'h0);
    wire request = wb_cyc_i && wb_stb_i;
    wire commit = request && wb_ack_o && wb_we_i && wb_sel_i[0];
    wire [7:0] wbyte = wb_dat_i[7:0];
    wire hit_loop = in_range && (index == pll_cfg_pkg::IDX_LOOP_CTRL);
    wire hit_ref_low = in_range && (index == pll_cfg_pkg::IDX_REF_LOW);
    wire hit_ref_high = in_range && (index == pll_cfg_pkg::IDX_REF_HIGH);
    wire hit_swallow = in_range && (index == pll_cfg_pkg::IDX_SWALLOW);
    wire hit_main_low = in_range && (index == pll_cfg_pkg::IDX_MAIN_LOW);
    wire hit_main_high = in_range && (index == pll_cfg_pkg::IDX_MAIN_HIGH);
    wire hit_pin = in_range && (index == pll_cfg_pkg::IDX_PIN_CTRL);
    wire hit_status = in_range && (index == pll_cfg_pkg::IDX_STATUS);
    wire wr_loop = commit && hit_loop;
    wire wr_ref_low = commit && hit_ref_low;
    wire wr_ref_high = commit && hit_ref_high;
    wire wr_swallow = commit && hit_swallow;
    wire wr_main_low = commit && hit_main_low;
    wire wr_main_high = commit && hit_main_high;
    wire wr_pin = commit && hit_pin;

    // ==========================================================
    // fields
    wire pll_cfg_pkg::loop_power_t power_mode =
        pll_cfg_pkg::loop_power_t'(loop_ctrl[pll_cfg_pkg::PD_LSB +: 2]);
    wire pll_cfg_pkg::pump_force_mode_t pump_mode =
        pll_cfg_pkg::pump_force_mode_t'(loop_ctrl[pll_cfg_pkg::MODE_LSB +: 2]);
    wire loop_on = (power_mode == pll_cfg_pkg::LOOP_RUN);
    wire [pll_cfg_pkg::REF_W-1:0] ref_divide = {ref_high, ref_low};
    wire [pll_cfg_pkg::MAIN_W-1:0] main_divide = {main_high, main_low};
    wire bypass = pin_ctrl[pll_cfg_pkg::BYPASS_BIT];
    wire [pll_cfg_pkg::MAIN_W-1:0] fb_divide =
        bypass ? pll_cfg_pkg::MAIN_W'(1) : main_divide;
    wire hold_all = pin_ctrl[pll_cfg_pkg::RST_ALL_BIT] || !loop_on;
    wire hold_ref = hold_all || pin_ctrl[pll_cfg_pkg::RST_REF_BIT];
    wire hold_fb = hold_all || pin_ctrl[pll_cfg_pkg::RST_FB_BIT];

    // ==========================================================
    // read mux; unused bits come back as zero
    wire [7:0] status = {3'h0, pump_mid, pump_down, pump_up, hold_fb, hold_ref};
    wire [7:0] lane_ref_high = {2'h0, ref_high};
    wire [7:0] lane_swallow = {2'h0, swallow};
    wire [7:0] lane_main_high = {3'h0, main_high};
    wire [7:0] rbyte =
        ({8{hit_loop}} & loop_ctrl) |
        ({8{hit_ref_low}} & ref_low) |
        ({8{hit_ref_high}} & lane_ref_high) |
        ({8{hit_swallow}} & lane_swallow) |
        ({8{hit_main_low}} & main_low) |
        ({8{hit_main_high}} & lane_main_high) |
        ({8{hit_pin}} & pin_ctrl) |
        ({8{hit_status}} & status);

    // ==========================================================
    // ack one cycle after the request, dropped the cycle after
    wire answer = request && !wb_ack_o;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= answer;
        end
    end

    // data stands only with ack, so a stale byte never leaks onto the bus
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            wb_dat_o <= 32'h0;
        end else begin
            wb_dat_o <= answer ? {24'h0, rbyte} : 32'h0;
        end
    end

    // ==========================================================
    // next values; a byte lands only on the ack edge of a write
    // pin control keeps bits 2..0 at zero, they have no function
    wire [7:0] pin_used = {wbyte[pll_cfg_pkg::MID_BIT:pll_cfg_pkg::BYPASS_BIT], {pll_cfg_pkg::BYPASS_BIT{1'b0}}};
    wire [7:0] next_loop_ctrl = wr_loop ? wbyte : loop_ctrl;
    wire [7:0] next_ref_low = wr_ref_low ? wbyte : ref_low;
    wire [5:0] next_ref_high = wr_ref_high ? wbyte[pll_cfg_pkg::REF_HIGH_W-1:0] : ref_high;
    wire [5:0] next_swallow = wr_swallow ? wbyte[pll_cfg_pkg::SWALLOW_W-1:0] : swallow;
    wire [7:0] next_main_low = wr_main_low ? wbyte : main_low;
    wire [4:0] next_main_high = wr_main_high ? wbyte[pll_cfg_pkg::MAIN_HIGH_W-1:0] : main_high;
    wire [7:0] next_pin_ctrl = wr_pin ? pin_used : pin_ctrl;

    // ==========================================================
    // register storage, one short block per register
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            loop_ctrl <= pll_cfg_pkg::RST_LOOP_CTRL;
        end else begin
            loop_ctrl <= next_loop_ctrl;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ref_low <= pll_cfg_pkg::RST_REF_LOW;
        end else begin
            ref_low <= next_ref_low;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ref_high <= pll_cfg_pkg::RST_REF_HIGH;
        end else begin
            ref_high <= next_ref_high;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            swallow <= pll_cfg_pkg::RST_SWALLOW;
        end else begin
            swallow <= next_swallow;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            main_low <= pll_cfg_pkg::RST_MAIN_LOW;
        end else begin
            main_low <= next_main_low;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            main_high <= pll_cfg_pkg::RST_MAIN_HIGH;
        end else begin
            main_high <= next_main_high;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pin_ctrl <= pll_cfg_pkg::RST_PIN_CTRL;
        end else begin
            pin_ctrl <= next_pin_ctrl;
        end
    end

    // ==========================================================
    // phase detector inputs arrive from another timing domain
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pfd_up_s1 <= 1'b0;
            pfd_up_s2 <= 1'b0;
            pfd_down_s1 <= 1'b0;
            pfd_down_s2 <= 1'b0;
        end else begin
            pfd_up_s1 <= pfd_up;
            pfd_up_s2 <= pfd_up_s1;
            pfd_down_s1 <= pfd_down;
            pfd_down_s2 <= pfd_down_s1;
        end
    end

    // ==========================================================
    // static settings out, registered
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pump_current <= pll_cfg_pkg::RST_LOOP_CTRL[pll_cfg_pkg::CUR_LSB +: pll_cfg_pkg::CUR_W];
        end else begin
            pump_current <= loop_ctrl[pll_cfg_pkg::CUR_LSB +: pll_cfg_pkg::CUR_W];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pfd_negative <= pll_cfg_pkg::RST_LOOP_CTRL[pll_cfg_pkg::POL_BIT];
        end else begin
            pfd_negative <= loop_ctrl[pll_cfg_pkg::POL_BIT];
        end
    end

    // swallow value parks at zero while the feedback side is held
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            swallow_out <= pll_cfg_pkg::RST_SWALLOW;
        end else begin
            swallow_out <= hold_fb ? pll_cfg_pkg::RST_SWALLOW : swallow;
        end
    end

    // ==========================================================
    // loop counters and pump
    loop_counter #(
        .W(pll_cfg_pkg::REF_W)
    ) ref_counter (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .hold(hold_ref),
        .divide(ref_divide),
        .tick(ref_tick)
    );

    loop_counter #(
        .W(pll_cfg_pkg::MAIN_W)
    ) fb_counter (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .hold(hold_fb),
        .divide(fb_divide),
        .tick(fb_tick)
    );

    pump_drive pump (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .mode(pump_mode),
        .loop_on(loop_on),
        .set_mid(pin_ctrl[pll_cfg_pkg::MID_BIT]),
        .pfd_up(pfd_up_s2),
        .pfd_down(pfd_down_s2),
        .pump_up(pump_up),
        .pump_down(pump_down),
        .pump_hiz(pump_hiz),
        .pump_mid(pump_mid)
    );

endmodule

// ===== verif/pll_divider_config_regs_monitor.sv
`timescale 1ns/1ns
module pll_divider_config_regs_monitor (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    // pump and counters
    input wire logic pfd_up,
    input wire logic pfd_down,
    input wire logic pump_up,
    input wire logic pump_down,
    input wire logic pump_hiz,
    input wire logic pump_mid,
    input wire logic [2:0] pump_current,
    input wire logic pfd_negative,
    input wire logic ref_tick,
    input wire logic fb_tick,
    input wire logic [5:0] swallow_out
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // ==========================================================
    // shadow of loop and pin control, updated at the ack edge
    logic [7:0] loop_ctrl;
    logic mid;
    wire take = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
    wire run = loop_ctrl[1:0] == 2'h0 && !mid;
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            loop_ctrl <= 8'h7D;
            mid <= 1'b0;
        end else if (take && wb_adr_i == 8'h40) begin
            loop_ctrl <= wb_dat_i[7:0];
        end else if (take && wb_adr_i == 8'h58) begin
            mid <= wb_dat_i[7];
        end
    end
    // ==========================================================
    // properties
    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    AST_ACK_IDLE: assert property (!wb_cyc_i |=> !wb_ack_o) else $error("ack without cycle");
    AST_DAT_UPPER: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper data set");
    AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data while idle");
    AST_FORCE_UP: assert property (run && loop_ctrl[3:2] == 2'h1 |=> pump_up && !pump_down && !pump_hiz)
        else $error("pump not forced up");
    AST_FORCE_DOWN: assert property (run && loop_ctrl[3:2] == 2'h2 |=> pump_down && !pump_up && !pump_hiz)
        else $error("pump not forced down");
    AST_POWER_DOWN: assert property ((loop_ctrl[1:0] != 2'h0) [*2] |=> pump_hiz && !ref_tick && !fb_tick)
        else $error("loop active while powered down");
    AST_CURRENT: assert property ($stable(loop_ctrl) |-> pump_current == loop_ctrl[6:4])
        else $error("pump current mismatch");
    AST_POLARITY: assert property ($stable(loop_ctrl) |-> pfd_negative == loop_ctrl[7])
        else $error("detector polarity mismatch");
    AST_MID_SUPPLY: assert property (mid |=> pump_mid && pump_hiz && !pump_up && !pump_down)
        else $error("mid supply not applied");
    cover property (take && wb_adr_i == 8'h40);
    cover property (pump_up);
    cover property (pump_down);
    cover property (ref_tick);
endmodule
bind pll_divider_config_regs pll_divider_config_regs_monitor mon (.clk_sys(clk_sys), .resetn(resetn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .pfd_up(pfd_up), .pfd_down(pfd_down),
    .pump_up(pump_up), .pump_down(pump_down), .pump_hiz(pump_hiz), .pump_mid(pump_mid),
    .pump_current(pump_current), .pfd_negative(pfd_negative), .ref_tick(ref_tick), .fb_tick(fb_tick),
    .swallow_out(swallow_out));

// ===== verif/pll_divider_config_regs_tb.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
    $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module pll_divider_config_regs_tb;
    // ==========================================================
    // stimulus and model
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wd = 32'h0;
    logic ack, up, down, hiz, tick;
    logic mid, neg, tick_fb;
    logic [2:0] cur;
    logic [5:0] swallow;
    int cf;
    logic [31:0] rd_bus;
    logic [31:0] rd;
    logic pu = 1'b0;
    logic pd = 1'b0;
    int failures = 0;
    int total_checks = 0;
    int model [int];
    int mask [int];
    int c;
    always #2 clk_sys = ~clk_sys;
    pll_divider_config_regs dut (.clk_sys(clk_sys), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_ack_o(ack), .wb_dat_o(rd_bus),
        .pfd_up(pu), .pfd_down(pd), .pump_up(up), .pump_down(down), .pump_hiz(hiz), .pump_mid(mid),
        .pump_current(cur), .pfd_negative(neg), .ref_tick(tick), .fb_tick(tick_fb), .swallow_out(swallow));
    task automatic results();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic bus(input logic w, input int idx, input logic [3:0] s, input logic [31:0] d);
        int k;
        cyc <= 1'b1;
        we <= w;
        adr <= 8'(idx * 4);
        sel <= s;
        wd <= d;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (ack !== 1'b1 && k < 20);
        if (k >= 20)
            failures++;
        rd = rd_bus;
        cyc <= 1'b0;
        we <= 1'b0;
        if (w && s[0] && mask.exists(idx))
            model[idx] = d[7:0] & mask[idx];
        @(posedge clk_sys);
    endtask
    task automatic rd_chk(input int idx);
        bus(1'b0, idx, 4'hF, 32'h0);
        `CHK("register", 32'(model.exists(idx) ? model[idx] : 0), rd)
    endtask
    task automatic ticks(input int n);
        c = 0;
        cf = 0;
        repeat (n) begin
            @(posedge clk_sys);
            c += int'(tick);
            cf += int'(tick_fb);
        end
    endtask
    // ==========================================================
    // sequence
    initial begin
        void'($urandom(5961));
        model = '{16: 8'h7D, 17: 8'h01, 18: 0, 19: 0, 20: 8'h03, 21: 0, 22: 0};
        mask = '{16: 8'hFF, 17: 8'hFF, 18: 8'h3F, 19: 8'h3F, 20: 8'hFF, 21: 8'h1F, 22: 8'hF8};
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        for (int i = 16; i < 23; i++)
            rd_chk(i);
        for (int i = 16; i < 23; i++) begin
            bus(1'b1, i, 4'hF, $urandom());
            rd_chk(i);
            bus(1'b1, i, 4'hE, $urandom());
            rd_chk(i);
        end
        bus(1'b1, 8, 4'hF, 32'hFF);
        rd_chk(8);
        bus(1'b1, 22, 4'hF, 32'h0);
        for (int m = 0; m < 4; m++) begin
            pu <= 1'($urandom());
            pd <= ~pu;
            bus(1'b1, 16, 4'hF, 32'(m << 2));
            repeat (4) @(posedge clk_sys);
            `CHK("pump_up", 1'(m == 1 || (m == 3 && pu)), up)
            `CHK("pump_down", 1'(m == 2 || (m == 3 && pd)), down)
            `CHK("pump_hiz", 1'(m == 0 || (m == 3 && !pu && !pd)), hiz)
        end
        for (int p = 1; p < 4; p++) begin
            bus(1'b1, 16, 4'hF, 32'(12 | p));
            repeat (3) @(posedge clk_sys);
            ticks(20);
            `CHK("held ticks", 0, c)
            `CHK("held fb ticks", 0, cf)
            `CHK("pump_hiz", 1'b1, hiz)
        end
        pu <= 1'b0;
        pd <= 1'b0;
        bus(1'b1, 17, 4'hF, 32'h4);
        bus(1'b1, 18, 4'hF, 32'h0);
        bus(1'b1, 19, 4'hF, 32'h15);
        bus(1'b1, 20, 4'hF, 32'h5);
        bus(1'b1, 21, 4'hF, 32'h0);
        bus(1'b1, 16, 4'hF, 32'hEC);
        for (int h = 0; h < 3; h++) begin
            bus(1'b1, 22, 4'hF, 32'(h == 1 ? 8'h20 : (h == 2 ? 8'h08 : 8'h00)));
            repeat (8) @(posedge clk_sys);
            ticks(40);
            `CHK("ref ticks", 10, c)
            `CHK("fb ticks", (h == 1 ? 0 : (h == 2 ? 40 : 8)), cf)
            `CHK("swallow_out", (h == 1 ? 0 : 8'h15), swallow)
        end
        `CHK("pump_current", 3'h6, cur)
        `CHK("pfd_negative", 1'b1, neg)
        bus(1'b1, 16, 4'hF, 32'h4);
        bus(1'b1, 22, 4'hF, 32'h80);
        repeat (4) @(posedge clk_sys);
        `CHK("pump_mid", 1'b1, mid)
        `CHK("pump_up", 1'b0, up)
        `CHK("pump_hiz", 1'b1, hiz)
        bus(1'b0, 23, 4'hF, 32'h0);
        `CHK("status", 32'h10, rd)
        bus(1'b1, 22, 4'hF, 32'h0);
        repeat (4) @(posedge clk_sys);
        `CHK("pump_up", 1'b1, up)
        `CHK("pump_mid", 1'b0, mid)
        results();
    end
    initial begin
        #100000;
        failures++;
        results();
    end
endmodule
